// ---- cbf_pkg.sv ----
`default_nettype none
// ----------------------------------------------------------------------
// Shared constants for the receive buffer full pin block
// ----------------------------------------------------------------------
package cbf_pkg;

    // Register addresses on the internal register port
    localparam logic [7:0] ADDR_BUF0_CTRL  = 8'h60; // Buffer zero control
    localparam logic [7:0] ADDR_PIN_CTRL   = 8'h0c; // Full pin control
    localparam logic [7:0] ADDR_INT_FLAG   = 8'h2c; // Interrupt flags

    // Buffer zero control field positions
    localparam int CTRL_MODE_HI  = 6;  // Filter mode field top bit
    localparam int CTRL_MODE_LO  = 5;  // Filter mode field low bit
    localparam int CTRL_RTR      = 3;  // Remote request received
    localparam int CTRL_ROLL     = 2;  // Rollover enable
    localparam int CTRL_ROLL_CPY = 1;  // Rollover copy
    localparam int CTRL_HIT      = 0;  // Filter hit flag

    // Full pin control field positions
    localparam int PIN_MODE0  = 0;  // Pin zero mode
    localparam int PIN_MODE1  = 1;  // Pin one mode
    localparam int PIN_EN0    = 2;  // Pin zero enable
    localparam int PIN_EN1    = 3;  // Pin one enable
    localparam int PIN_STATE0 = 4;  // Pin zero state
    localparam int PIN_STATE1 = 5;  // Pin one state

    // Interrupt flag field positions
    localparam int FLAG_RX0 = 0;  // Buffer zero receive flag
    localparam int FLAG_RX1 = 1;  // Buffer one receive flag

    // Reset values
    localparam logic [7:0] RST_BYTE   = 8'h00; // All registers clear
    localparam logic [1:0] RST_MODE   = 2'h0;  // Filters, any identifier
    localparam logic [7:0] FULL_MASK  = 8'hff; // Whole byte write mask

    // Receive filter modes
    typedef enum logic [1:0] {
        MODE_ANY_FILT = 2'h0,  // Filtered, either identifier type
        MODE_STD_FILT = 2'h1,  // Filtered, standard identifiers only
        MODE_EXT_FILT = 2'h2,  // Filtered, extended identifiers only
        MODE_NO_FILT  = 2'h3   // Masks and filters bypassed
    } cbf_mode_t;

    // Masked merge used by plain write and bit modify alike
    function automatic logic [7:0] cbf_merge(
        input logic [7:0] old_val,
        input logic [7:0] new_val,
        input logic [7:0] mask
    );
        cbf_merge = (old_val & ~mask) | (new_val & mask);
    endfunction

endpackage
`default_nettype wire

// ---- cbf_pin.sv ----
`default_nettype none
// ----------------------------------------------------------------------
// One buffer full pin driver, active low, registered
// ----------------------------------------------------------------------
module cbf_pin (
    input  wire logic clk,       // System clock
    input  wire logic rst,       // Synchronous reset, high
    input  wire logic pin_en,    // Full pin enable
    input  wire logic pin_mode,  // One: interrupt, zero: output
    input  wire logic pin_state, // Level in output mode
    input  wire logic rx_flag,   // Buffer receive flag
    output logic      pin_n      // Pin level, low means full
);
    import cbf_pkg::*;

    logic pin_d; // Next pin level

    // Pin level selection
    always_comb begin
        if (!pin_en) begin
            pin_d = 1'b1;       // Disabled, held high
        end else if (pin_mode) begin
            pin_d = ~rx_flag;   // Low while flag set
        end else begin
            pin_d = pin_state;  // Software level only
        end
    end

    // Pin register
    always_ff @(posedge clk) begin
        if (rst) begin
            pin_n <= 1'b1;
        end else begin
            pin_n <= pin_d;
        end
    end

endmodule
`default_nettype wire

// ---- cbf_accept.sv ----
`default_nettype none
// ----------------------------------------------------------------------
// Buffer zero acceptance decision per filter mode
// ----------------------------------------------------------------------
module cbf_accept (
    input  wire cbf_pkg::cbf_mode_t  rx_mode,  // Filter mode field
    input  wire logic                msg_ext,  // Extended identifier
    input  wire logic [1:0]          filt_hit, // Filter one, filter zero
    output logic                     accept,   // Buffer zero accepts
    output logic                     hit_sel   // One when filter one hit and filter zero did not
);
    import cbf_pkg::*;

    logic any_hit; // Some filter matched

    // Mode dependent acceptance
    always_comb begin
        any_hit = |filt_hit;
        hit_sel = ~filt_hit[0] & filt_hit[1]; // Filter zero first
        unique case (rx_mode)
            MODE_NO_FILT:  accept = 1'b1;
            MODE_EXT_FILT: accept = any_hit & msg_ext;
            MODE_STD_FILT: accept = any_hit & ~msg_ext;
            MODE_ANY_FILT: accept = any_hit;
        endcase
    end

endmodule
`default_nettype wire

// ---- cbf_top.sv ----
`default_nettype none
// Summary of operation
// - Two full pins, one per buffer
// - Enable and mode set: pin follows flag
// - Flag set by load drives pin low
// - Flag cleared returns pin high
// - Output mode: pin from state bit only
// - State one drives high, zero low
// - Mode 11 accepts any message
// - Mode 10 extended, 01 standard, filtered
// - Mode 00 accepts all filtered messages
// - Bit 3 read-only remote request flag
// - Bits 7 and 4 read zero
// - Load sets flag; host clears it
// - Rollover moves overflow into buffer one
// - Bit 0 shows which filter hit
module cbf_top (
    input  wire logic       CLK_SYS,    // System clock, 25 MHz
    input  wire logic       RST,        // Synchronous reset, high
    input  wire logic       REG_WR,     // Register write strobe
    input  wire logic [7:0] REG_ADDR,   // Register address
    input  wire logic [7:0] REG_WDATA,  // Write data
    input  wire logic [7:0] REG_MASK,   // Bit modify mask
    input  wire logic       REG_RD,     // Register read strobe
    input  wire logic       MSG_VALID,  // Assembled message ready, pulse
    input  wire logic       MSG_EXT,    // Extended identifier
    input  wire logic       MSG_RTR,    // Remote transfer request
    input  wire logic [1:0] MSG_HIT0,   // Buffer zero filter hits
    input  wire logic       MSG_HIT1,   // Buffer one criteria met
    output logic [7:0]      REG_RDATA,  // Read data, registered
    output logic            LOAD_BUF0,  // Message moved to buffer zero
    output logic            LOAD_BUF1,  // Message moved to buffer one
    output logic            BUFFER0_FULL_PIN_N, // Buffer zero full
    output logic            BUFFER1_FULL_PIN_N  // Buffer one full
);
    import cbf_pkg::*;

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    cbf_mode_t  mode_q, mode_d;     // Receive filter mode field
    logic       rtr_q, rtr_d;       // Remote request received
    logic       roll_q, roll_d;     // Rollover enable
    logic       hit_q, hit_d;       // Filter hit flag
    logic [5:0] pinc_q, pinc_d;     // Full pin control bits
    logic [1:0] flag_q, flag_d;     // Receive flags
    logic [7:0] rdata_d;            // Next read data
    logic       ld0_d, ld1_d;       // Next load pulses
    logic       ld0_q, ld1_q;       // Load pulses
    logic [7:0] ctrl_rd;            // Buffer zero control view
    logic [7:0] pin_rd;             // Pin control view
    logic [7:0] flag_rd;            // Flag view
    logic [7:0] ctrl_new;           // Merged control write
    logic [7:0] pin_new;            // Merged pin control write
    logic [7:0] flag_new;           // Merged flag write
    logic       acc0;               // Buffer zero criteria met
    logic       hit_sel;            // Filter one matched, filter zero did not

    // ------------------------------------------------------------------
    // Acceptance
    // ------------------------------------------------------------------

    // Filter mode check for buffer zero
    cbf_accept u_accept (
        .rx_mode  (mode_q),
        .msg_ext  (MSG_EXT),
        .filt_hit (MSG_HIT0),
        .accept   (acc0),
        .hit_sel  (hit_sel)
    );

    // ------------------------------------------------------------------
    // Register views
    // ------------------------------------------------------------------

    // Read images of the three registers
    always_comb begin
        ctrl_rd                            = RST_BYTE;
        ctrl_rd[CTRL_MODE_HI:CTRL_MODE_LO] = mode_q;
        ctrl_rd[CTRL_RTR]                  = rtr_q;
        ctrl_rd[CTRL_ROLL]                 = roll_q;
        ctrl_rd[CTRL_ROLL_CPY]             = roll_q;
        ctrl_rd[CTRL_HIT]                  = hit_q;
        pin_rd                             = {2'h0, pinc_q};
        flag_rd                            = {6'h00, flag_q};
        ctrl_new = cbf_merge(ctrl_rd, REG_WDATA, REG_MASK);
        pin_new  = cbf_merge(pin_rd, REG_WDATA, REG_MASK);
        flag_new = cbf_merge(flag_rd, REG_WDATA, REG_MASK);
    end

    // ------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------

    // Register writes, message loads and read data
    always_comb begin
        mode_d = mode_q;
        rtr_d  = rtr_q;
        roll_d = roll_q;
        hit_d  = hit_q;
        pinc_d = pinc_q;
        flag_d = flag_q;
        ld0_d  = 1'b0;
        ld1_d  = 1'b0;
        // Host writes; only writable fields change
        if (REG_WR) begin
            unique case (REG_ADDR)
                ADDR_BUF0_CTRL: begin
                    mode_d = cbf_mode_t'(
                        ctrl_new[CTRL_MODE_HI:CTRL_MODE_LO]);
                    roll_d = ctrl_new[CTRL_ROLL];
                end
                ADDR_PIN_CTRL: begin
                    pinc_d = pin_new[5:0];
                end
                ADDR_INT_FLAG: begin
                    flag_d = flag_q & flag_new[1:0]; // Host clears
                end
                default: begin
                    mode_d = mode_q; // Unmapped, ignored
                end
            endcase
        end
        // Message loads; a set beats a same cycle clear
        if (MSG_VALID) begin
            if (acc0 && !flag_q[FLAG_RX0]) begin
                ld0_d            = 1'b1;
                flag_d[FLAG_RX0] = 1'b1;
                rtr_d            = MSG_RTR;
                hit_d            = hit_sel;
            end else if (acc0 && roll_q && !flag_q[FLAG_RX1]) begin
                ld1_d            = 1'b1;
                flag_d[FLAG_RX1] = 1'b1;
                hit_d            = hit_sel;
            end else if (MSG_HIT1 && !flag_q[FLAG_RX1]) begin
                ld1_d            = 1'b1;
                flag_d[FLAG_RX1] = 1'b1;
            end
        end
        // Read data
        rdata_d = REG_RDATA;
        if (REG_RD) begin
            unique case (REG_ADDR)
                ADDR_BUF0_CTRL: rdata_d = ctrl_rd;
                ADDR_PIN_CTRL:  rdata_d = pin_rd;
                ADDR_INT_FLAG:  rdata_d = flag_rd;
                default:        rdata_d = RST_BYTE;
            endcase
        end
    end

    // ------------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------------

    // Register update
    always_ff @(posedge CLK_SYS) begin
        if (RST) begin
            mode_q    <= cbf_mode_t'(RST_MODE);
            rtr_q     <= 1'b0;
            roll_q    <= 1'b0;
            hit_q     <= 1'b0;
            pinc_q    <= RST_BYTE[5:0];
            flag_q    <= RST_BYTE[1:0];
            ld0_q     <= 1'b0;
            ld1_q     <= 1'b0;
            REG_RDATA <= RST_BYTE;
        end else begin
            mode_q    <= mode_d;
            rtr_q     <= rtr_d;
            roll_q    <= roll_d;
            hit_q     <= hit_d;
            pinc_q    <= pinc_d;
            flag_q    <= flag_d;
            ld0_q     <= ld0_d;
            ld1_q     <= ld1_d;
            REG_RDATA <= rdata_d;
        end
    end

    assign LOAD_BUF0 = ld0_q;
    assign LOAD_BUF1 = ld1_q;

    // ------------------------------------------------------------------
    // Full pins
    // ------------------------------------------------------------------

    // Buffer zero pin
    cbf_pin u_pin0 (
        .clk       (CLK_SYS),
        .rst       (RST),
        .pin_en    (pinc_q[PIN_EN0]),
        .pin_mode  (pinc_q[PIN_MODE0]),
        .pin_state (pinc_q[PIN_STATE0]),
        .rx_flag   (flag_q[FLAG_RX0]),
        .pin_n     (BUFFER0_FULL_PIN_N)
    );

    // Buffer one pin
    cbf_pin u_pin1 (
        .clk       (CLK_SYS),
        .rst       (RST),
        .pin_en    (pinc_q[PIN_EN1]),
        .pin_mode  (pinc_q[PIN_MODE1]),
        .pin_state (pinc_q[PIN_STATE1]),
        .rx_flag   (flag_q[FLAG_RX1]),
        .pin_n     (BUFFER1_FULL_PIN_N)
    );

endmodule
`default_nettype wire

// ---- cbf_chk.sv ----
`default_nettype none
// ----------------------------------------------------------------------
// Port checks for the full pin block
// ----------------------------------------------------------------------
module cbf_chk import cbf_pkg::*; (
    input wire logic       CLK_SYS,
    input wire logic       RST,
    input wire logic       REG_WR,
    input wire logic [7:0] REG_ADDR,
    input wire logic [7:0] REG_WDATA,
    input wire logic [7:0] REG_MASK,
    input wire logic       REG_RD,
    input wire logic       MSG_VALID,
    input wire logic [7:0] REG_RDATA,
    input wire logic       LOAD_BUF0,
    input wire logic       LOAD_BUF1,
    input wire logic       BUFFER0_FULL_PIN_N,
    input wire logic       BUFFER1_FULL_PIN_N
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [5:0] pc_q; // Shadow of pin control
    logic [5:0] pc_d; // Its next value
    logic       in0;  // Pin zero in interrupt mode
    logic       in1;  // Pin one in interrupt mode
    assign in0 = pc_q[PIN_EN0] && pc_q[PIN_MODE0];
    assign in1 = pc_q[PIN_EN1] && pc_q[PIN_MODE1];
    // Masked update of the shadow
    always_comb begin
        pc_d = pc_q;
        if (REG_WR && REG_ADDR == ADDR_PIN_CTRL) begin
            pc_d = (pc_q & ~REG_MASK[5:0]) | (REG_WDATA[5:0] & REG_MASK[5:0]);
        end
    end
    always_ff @(posedge CLK_SYS) begin
        if (RST) begin
            pc_q <= 6'h00;
        end else begin
            pc_q <= pc_d;
        end
    end
    default clocking @(posedge CLK_SYS); endclocking
    default disable iff (RST);
    a_pin_off_high: assert property (
        !$past(pc_q[PIN_EN0]) |-> BUFFER0_FULL_PIN_N)
        else $error("pin zero low while disabled");
    a_pin1_off_high: assert property (
        !$past(pc_q[PIN_EN1]) |-> BUFFER1_FULL_PIN_N)
        else $error("pin one low while disabled");
    a_out_level0: assert property (
        $past(pc_q[PIN_EN0]) && !$past(pc_q[PIN_MODE0])
        |-> BUFFER0_FULL_PIN_N == $past(pc_q[PIN_STATE0]))
        else $error("pin zero not at its state bit");
    a_out_level1: assert property (
        $past(pc_q[PIN_EN1]) && !$past(pc_q[PIN_MODE1])
        |-> BUFFER1_FULL_PIN_N == $past(pc_q[PIN_STATE1]))
        else $error("pin one not at its state bit");
    a_load_pin0: assert property (
        LOAD_BUF0 && in0 |=> !BUFFER0_FULL_PIN_N)
        else $error("pin zero not low after load");
    a_load_pin1: assert property (
        LOAD_BUF1 && in1 |=> !BUFFER1_FULL_PIN_N)
        else $error("pin one not low after load");
    a_hold_high: assert property (
        in0 && $past(in0) && BUFFER0_FULL_PIN_N && !LOAD_BUF0
        |=> BUFFER0_FULL_PIN_N)
        else $error("pin zero fell without a load");
    a_load_cause: assert property (
        LOAD_BUF0 || LOAD_BUF1 |-> $past(MSG_VALID))
        else $error("load without a message");
    a_load_single: assert property (
        !(LOAD_BUF0 && LOAD_BUF1))
        else $error("one message loaded twice");
    a_ctrl_fixed: assert property (
        REG_RD && REG_ADDR == ADDR_BUF0_CTRL |=>
        !REG_RDATA[7] && !REG_RDATA[4] && REG_RDATA[1] == REG_RDATA[2])
        else $error("control read has bad fixed bits");
endmodule
bind cbf_top cbf_chk u_chk (
    .CLK_SYS(CLK_SYS), .RST(RST), .REG_WR(REG_WR), .REG_ADDR(REG_ADDR),
    .REG_WDATA(REG_WDATA), .REG_MASK(REG_MASK), .REG_RD(REG_RD),
    .MSG_VALID(MSG_VALID), .REG_RDATA(REG_RDATA), .LOAD_BUF0(LOAD_BUF0),
    .LOAD_BUF1(LOAD_BUF1), .BUFFER0_FULL_PIN_N(BUFFER0_FULL_PIN_N),
    .BUFFER1_FULL_PIN_N(BUFFER1_FULL_PIN_N)
);
`default_nettype wire

// ---- cbf_host.sv ----
`default_nettype none
// ----------------------------------------------------------------------
// Host side of the register port
// ----------------------------------------------------------------------
module cbf_host (
    input  wire logic       clk,
    input  wire logic [7:0] rdata,
    output var  logic       wr,
    output var  logic       rd,
    output var  logic [7:0] addr,
    output var  logic [7:0] wdata,
    output var  logic [7:0] mask
);
    import cbf_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        wr = 1'b0;
        rd = 1'b0;
        addr = 8'h00;
        wdata = 8'h00;
        mask = 8'h00;
    end
    // One write strobe; idle lines show the inverse
    task automatic put(input logic [7:0] a, d, m);
        @(negedge clk);
        addr = a;
        wdata = d;
        mask = m;
        wr = 1'b1;
        @(negedge clk);
        wr = 1'b0;
        addr = ~a;
        wdata = ~d;
        mask = ~m;
    endtask
    // One read strobe, data taken a cycle later
    task automatic get(input logic [7:0] a, output logic [7:0] d);
        @(negedge clk);
        addr = a;
        rd = 1'b1;
        @(negedge clk);
        rd = 1'b0;
        addr = ~a;
        @(negedge clk);
        d = rdata;
    endtask
    // Clear receive flags under mask
    task automatic clr(input logic [7:0] m);
        put(ADDR_INT_FLAG, 8'h00, m);
    endtask
    // State bits only through bit modify
    task automatic mod(input logic [7:0] d);
        put(ADDR_PIN_CTRL, d, 8'h30);
    endtask
endmodule
`default_nettype wire

// ---- can_rx_buffer_full_pins_test.sv ----
`default_nettype none
module can_rx_buffer_full_pins_test;
    import cbf_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct packed {
        logic [1:0] mode;
        logic       ext;
        logic       rtr;
        logic [1:0] hit;
        logic       ld;
        logic       hb;
    } cbf_row_t;
    // Filter mode cases: inputs, then load and hit bit
    cbf_row_t rows [10] = '{8'h06, 8'h3b, 8'h00, 8'h0e, 8'h46,
                            8'h64, 8'hab, 8'h84, 8'he2, 8'hd2};
    logic       clk_sys = 1'b0;
    logic       rst = 1'b1;
    logic       reg_wr, reg_rd, msg_valid = 1'b0, msg_ext = 1'b0;
    logic       msg_rtr = 1'b0, msg_hit1 = 1'b0;
    logic [1:0] msg_hit0 = 2'h0;
    logic [7:0] reg_addr, reg_wdata, reg_mask, reg_rdata;
    logic       load0, load1, pin0_n, pin1_n, got0, got1;
    int         bad_count = 0;
    int         compares = 0;
    always #20 clk_sys = ~clk_sys;
    cbf_host host (.clk(clk_sys), .rdata(reg_rdata), .wr(reg_wr),
        .rd(reg_rd), .addr(reg_addr), .wdata(reg_wdata), .mask(reg_mask));
    cbf_top DUT (.CLK_SYS(clk_sys), .RST(rst), .REG_WR(reg_wr),
        .REG_ADDR(reg_addr), .REG_WDATA(reg_wdata), .REG_MASK(reg_mask),
        .REG_RD(reg_rd), .MSG_VALID(msg_valid), .MSG_EXT(msg_ext),
        .MSG_RTR(msg_rtr), .MSG_HIT0(msg_hit0), .MSG_HIT1(msg_hit1),
        .REG_RDATA(reg_rdata), .LOAD_BUF0(load0), .LOAD_BUF1(load1),
        .BUFFER0_FULL_PIN_N(pin0_n), .BUFFER1_FULL_PIN_N(pin1_n));
    task automatic close_out;
        $display("compares=%0d bad_count=%0d", compares, bad_count);
        if (bad_count == 0 && compares > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    task automatic chk_byte(input logic [7:0] got, exp);
        compares++;
        if (got !== exp) begin
            bad_count++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic chk_bit(input logic got, exp);
        chk_byte({7'h00, got}, {7'h00, exp});
    endtask
    // One message pulse; load outputs caught while they stand
    task automatic send(input logic e, r, input logic [1:0] h,
                        input logic h1);
        @(negedge clk_sys);
        msg_valid = 1'b1;
        msg_ext = e;
        msg_rtr = r;
        msg_hit0 = h;
        msg_hit1 = h1;
        @(negedge clk_sys);
        got0 = load0;
        got1 = load1;
        msg_valid = 1'b0;
        msg_hit0 = ~h;
        @(negedge clk_sys);
    endtask
    // Hang guard, well past the expected run
    initial begin
        #200000;
        bad_count++;
        close_out();
    end
    initial begin
        cbf_row_t   r;
        logic [7:0] d;
        logic [7:0] m;
        logic [7:0] e;
        repeat (4) @(negedge clk_sys);
        rst = 1'b0;
        foreach (rows[i]) begin
            r = rows[i];
            m = !r.ld ? 8'he0 : (r.hit == 2'b00 ? 8'hfe : 8'hff);
            host.put(ADDR_BUF0_CTRL, {1'b0, r.mode, 5'h00}, FULL_MASK);
            send(r.ext, r.rtr, r.hit, 1'b0);
            chk_bit(got0, r.ld);
            host.get(ADDR_BUF0_CTRL, d);
            e = {1'b0, r.mode, 1'b0, r.rtr, 2'b00, r.hb} & m;
            chk_byte(d & m, e);
            host.clr(8'h01);
        end
        // Second reset in mid-run, then read-only bits
        rst = 1'b1;
        repeat (4) @(negedge clk_sys);
        rst = 1'b0;
        chk_byte(reg_rdata, 8'h00);
        chk_bit(pin0_n & pin1_n, 1'b1);
        host.put(ADDR_BUF0_CTRL, 8'hff, FULL_MASK);
        host.get(ADDR_BUF0_CTRL, d);
        chk_byte(d, 8'h66);
        // Interrupt mode with rollover and overflow
        host.put(ADDR_BUF0_CTRL, 8'h04, FULL_MASK);
        host.put(ADDR_PIN_CTRL, 8'h0f, FULL_MASK);
        send(1'b0, 1'b0, 2'b01, 1'b0);
        @(negedge clk_sys);
        chk_bit(pin0_n, 1'b0);
        chk_bit(pin1_n, 1'b1);
        send(1'b0, 1'b0, 2'b10, 1'b0);
        chk_bit(got1, 1'b1);
        @(negedge clk_sys);
        chk_bit(pin1_n, 1'b0);
        host.get(ADDR_BUF0_CTRL, d);
        chk_byte(d, 8'h07);
        send(1'b0, 1'b0, 2'b01, 1'b1);
        chk_bit(got0 | got1, 1'b0);
        host.get(ADDR_INT_FLAG, d);
        chk_byte(d, 8'h03);
        host.clr(8'h01);
        repeat (2) @(negedge clk_sys);
        chk_bit(pin0_n, 1'b1);
        chk_bit(pin1_n, 1'b0);
        send(1'b0, 1'b0, 2'b01, 1'b0);
        chk_bit(got0, 1'b1);
        host.clr(8'h02);
        // Output mode ignores the flag
        host.put(ADDR_PIN_CTRL, 8'h1c, FULL_MASK);
        repeat (2) @(negedge clk_sys);
        chk_bit(pin0_n, 1'b1);
        chk_bit(pin1_n, 1'b0);
        host.mod(8'h20);
        @(negedge clk_sys);
        chk_bit(pin0_n, 1'b0);
        chk_bit(pin1_n, 1'b1);
        close_out();
    end
endmodule
`default_nettype wire
